/* hw/positioning_start_commands.sv */
/*
  Command front end of a two-axis positioning unit: direct and indirect
  start commands, operand checks, error and finish flags, step table,
  register port and interrupt. Assumes commands, operands and scanPulse
  come from host logic on ref_clk; scanPulse marks each host scan.
*/
// Summary of operation
// - command edge starts direct move on axis
// - direct move uses operand target data
// - control word selects method, coordinates, ramp
// - speed limit from stored parameter register
// - direct start forced end and single
// - bad axis sets instruction error, no start
// - busy or erroring axis ignores starts
// - no origin gives code 224, no motion
// - move, stop, dwell, finish, output code
// - indirect start runs chosen stored step
// - indirect supports end, continued, incessant, repeat
`timescale 1ns/1ps
`include "positioning_start_defines.svh"
module positioning_start_commands
  import positioning_start_pkg::*;
#(
  parameter int MS_CYCLES = `PS_MS_CYCLES
)
(
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  input  wire logic          scanPulse,
  input  wire logic          directStartCmd,
  input  wire direct_cmd_s   directOperands,
  input  wire logic          indirectStartCmd,
  input  wire indirect_cmd_s indirectOperands,
  input  wire logic [1:0]    originFixed,
  input  wire logic [7:0]    regAddr,
  input  wire logic [31:0]   regWdata,
  input  wire logic          regWrite,
  input  wire logic          regRead,
  output logic [31:0]        regRdata,
  output logic               instructionErrorFlag,
  output logic               axisXErrorFlag,
  output logic               axisYErrorFlag,
  output logic               axisXFinishFlag,
  output logic               axisYFinishFlag,
  output logic               axisXBusyFlag,
  output logic               axisYBusyFlag,
  output logic [1:0]         axisPulse,
  output logic [1:0]         axisDir,
  output logic               irq
);
  function automatic job_s makeJob(input step_entry_s e, input logic direct);
    job_s j;
    j.targetPos    = e.pos;
    j.targetSpeed  = e.speed;
    j.dwellMs      = e.dwellMs;
    j.mCode        = e.mCode;
    j.speedMode    = e.ctrl[`PS_CW_METHOD_BIT];
    j.incremental  = e.ctrl[`PS_CW_COORD_BIT];
    j.accelSel     = e.ctrl[`PS_CW_ACCEL_MSB:`PS_CW_ACCEL_LSB];
    j.pattern      = PAT_END;
    if (!direct && e.ctrl[`PS_CW_PATTERN_MSB:`PS_CW_PATTERN_LSB] != 2'h3)
      j.pattern = op_pattern_e'(e.ctrl[`PS_CW_PATTERN_MSB:`PS_CW_PATTERN_LSB]);
    j.repeatMethod = direct ? 1'b0 : e.ctrl[`PS_CW_REPEAT_BIT];
    j.repeatStep   = e.repeatStep;
    return j;
  endfunction

  logic               directPrev;
  logic               indirectPrev;
  logic               advancedMode;
  logic [1:0]         stopReq;
  logic [31:0]        speedLimit;
  logic [4:0]         status;
  logic [4:0]         mask;
  logic [15:0]        msCnt;
  logic               msTick;
  step_t              stgIndex;
  logic signed [31:0] stgPos;
  logic [31:0]        stgSpeed;
  logic [31:0]        stgTime;
  step_entry_s        stepTable [`PS_STEP_DEPTH];
  logic [1:0]         axisErr;
  logic [7:0]         errCode [2];
  step_t              stepWord [2];
  step_t              curStep [2];
  step_t              nextStep [2];
  job_s               curJob [2];
  logic [1:0]         curIndirect;
  logic [1:0]         chainPending;
  logic [1:0]         finishPend;
  logic [1:0]         finishFlag;
  logic [1:0]         engBusy;
  logic [1:0]         engDone;
  logic signed [31:0] position [2];
  logic [15:0]        mCodeOut [2];
  logic [1:0]         accelSel [2];
  logic [1:0]         startEng;
  job_s               engJob [2];
  job_s               tableJob [2];
  step_t              afterStep [2];
  logic [1:0]         chainOk;
  logic [1:0]         originErrSet;
  logic [1:0]         stepErrSet;
  logic [1:0]         finishSet;
  logic [1:0]         axisWr;

  wire directEdge   = scanPulse & directStartCmd & ~directPrev;
  wire indirectEdge = scanPulse & indirectStartCmd & ~indirectPrev & ~directEdge;
  wire cmdValid     = directEdge | indirectEdge;

  wire [15:0] cmdAxis = directEdge ? directOperands.axis : indirectOperands.axis;
  wire        axisOk  = (cmdAxis == 16'h0000) | (cmdAxis == 16'h0001);
  wire        cmdAx   = cmdAxis[0];
  wire step_t stepLimit = advancedMode ? `PS_STEP_MAX_ADV : `PS_STEP_MAX_STD;

  wire [15:0] reqStep = (indirectOperands.step == 16'h0000) ?
                        {9'h000, stepWord[cmdAx]} : indirectOperands.step;
  wire        stepOk  = reqStep <= {9'h000, stepLimit};

  wire axisFree  = ~engBusy[cmdAx] & ~chainPending[cmdAx] & ~axisErr[cmdAx];
  wire noOrigin  = ~originFixed[cmdAx];
  wire cmdUsable = cmdValid & axisOk & axisFree;
  wire cmdGo     = cmdUsable & ~noOrigin & (directEdge | stepOk);
  wire originErr = cmdUsable & noOrigin;
  wire stepErr   = cmdUsable & ~noOrigin & indirectEdge & ~stepOk;
  wire instrErrSet = cmdValid & ~axisOk;

  wire step_entry_s directEntry = {directOperands.targetPos, directOperands.targetSpeed,
                                   directOperands.dwellMs, directOperands.mCode,
                                   directOperands.controlWord, 7'h00};
  wire job_s directJob = makeJob(directEntry, 1'b1);

  wire ctrlWr   = regWrite & (regAddr == `PS_REG_CONTROL);
  wire statusWr = regWrite & (regAddr == `PS_REG_STATUS);
  wire commitWr = regWrite & (regAddr == `PS_REG_STEP_CTRL) &
                  (stgIndex <= `PS_STEP_MAX_ADV);
  wire [1:0] clrErr = ctrlWr ? regWdata[2:1] : 2'h0;
  wire [4:0] statusSet = {finishSet, originErrSet | stepErrSet, instrErrSet};

  assign axisWr = {regWrite & (regAddr == `PS_REG_AXIS_Y),
                   regWrite & (regAddr == `PS_REG_AXIS_X)};

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gAxis
      wire   mine    = cmdAx == 1'(g);
      wire step_t lookIdx = chainPending[g] ? nextStep[g] : reqStep[6:0];
      assign tableJob[g]  = makeJob(stepTable[lookIdx], 1'b0);
      assign startEng[g]  = chainPending[g] | (cmdGo & mine);
      assign engJob[g]    = (chainPending[g] | indirectEdge) ? tableJob[g] : directJob;
      assign afterStep[g] = curJob[g].repeatMethod ? curJob[g].repeatStep :
                            curStep[g] + 7'h01;
      assign chainOk[g]   = afterStep[g] <= stepLimit;
      assign originErrSet[g] = originErr & mine;
      assign stepErrSet[g]   = (stepErr & mine) |
                               (engDone[g] & curIndirect[g] &
                                (curJob[g].pattern != PAT_END) & ~chainOk[g]);
      assign finishSet[g] = engDone[g] &
                            (~curIndirect[g] | (curJob[g].pattern == PAT_END));

      axis_motion_engine i_axis_motion_engine (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .start      (startEng[g]),
        .job        (engJob[g]),
        .stopReq    (stopReq[g]),
        .msTick     (msTick),
        .speedLimit (speedLimit),
        .busy       (engBusy[g]),
        .done       (engDone[g]),
        .position   (position[g]),
        .mCode      (mCodeOut[g]),
        .pulseOut   (axisPulse[g]),
        .dirOut     (axisDir[g]),
        .accelSel   (accelSel[g])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      directPrev   <= 1'b0;
      indirectPrev <= 1'b0;
    end
    else if (scanPulse)
    begin
      directPrev   <= directStartCmd;
      indirectPrev <= indirectStartCmd;
    end
  end

  // millisecond tick for the dwell
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      msCnt  <= 16'h0000;
      msTick <= 1'b0;
    end
    else
    begin
      msTick <= msCnt == 16'(MS_CYCLES - 1);
      msCnt  <= (msCnt == 16'(MS_CYCLES - 1)) ? 16'h0000 : msCnt + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      instructionErrorFlag <= 1'b0;
    else if (instrErrSet)
      instructionErrorFlag <= 1'b1;
    else if (scanPulse)
      instructionErrorFlag <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      axisErr      <= 2'h0;
      curIndirect  <= 2'h0;
      chainPending <= 2'h0;
      finishPend   <= 2'h0;
      finishFlag   <= 2'h0;
      for (int i = 0; i < 2; i++)
      begin
        errCode[i]  <= 8'h00;
        stepWord[i] <= 7'h00;
        curStep[i]  <= 7'h00;
        nextStep[i] <= 7'h00;
        curJob[i]   <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (axisWr[i])
          stepWord[i] <= regWdata[6:0];
        if (startEng[i])
        begin
          curJob[i]       <= engJob[i];
          curIndirect[i]  <= chainPending[i] | indirectEdge;
          curStep[i]      <= chainPending[i] ? nextStep[i] : reqStep[6:0];
          chainPending[i] <= 1'b0;
        end
        if (engDone[i] && curIndirect[i])
        begin
          if (curJob[i].pattern == PAT_END || chainOk[i])
            stepWord[i] <= afterStep[i];
          if (curJob[i].pattern != PAT_END && chainOk[i])
          begin
            chainPending[i] <= 1'b1;
            nextStep[i]     <= afterStep[i];
          end
        end
        if (clrErr[i])
          axisErr[i] <= 1'b0;
        if (originErrSet[i])
        begin
          axisErr[i] <= 1'b1;
          errCode[i] <= `PS_ERR_NO_ORIGIN;
        end
        else if (stepErrSet[i])
        begin
          axisErr[i] <= 1'b1;
          errCode[i] <= `PS_ERR_STEP_RANGE;
        end
        if (scanPulse)
        begin
          finishFlag[i] <= finishPend[i];
          finishPend[i] <= 1'b0;
        end
        if (finishSet[i])
          finishPend[i] <= 1'b1;
      end
    end
  end

  // sticky events, set beats clear
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      status <= 5'h00;
      irq    <= 1'b0;
    end
    else
    begin
      status <= (status & ~(statusWr ? regWdata[4:0] : 5'h00)) | statusSet;
      irq    <= |(status & mask);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      mask         <= `PS_MASK_RESET;
      advancedMode <= 1'b0;
      stopReq      <= 2'h0;
      speedLimit   <= `PS_SPEED_LIMIT_RST;
      stgIndex     <= 7'h00;
      stgPos       <= 32'sh00000000;
      stgSpeed     <= 32'h00000000;
      stgTime      <= 32'h00000000;
    end
    else if (regWrite)
    begin
      unique case (regAddr)
        `PS_REG_MASK:        mask <= regWdata[4:0];
        `PS_REG_CONTROL:
        begin
          advancedMode <= regWdata[0];
          stopReq      <= regWdata[4:3];
        end
        `PS_REG_STEP_INDEX:  stgIndex <= regWdata[6:0];
        `PS_REG_STEP_POS:    stgPos <= regWdata;
        `PS_REG_STEP_SPEED:  stgSpeed <= regWdata;
        `PS_REG_STEP_TIME:   stgTime <= regWdata;
        `PS_REG_SPEED_LIMIT: speedLimit <= regWdata;
        default:             mask <= mask;
      endcase
    end
  end

  // table is data only; a step is stored by the control-word write
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      for (int k = 0; k < `PS_STEP_DEPTH; k++)
        stepTable[k] <= '0;
    end
    else if (commitWr)
      stepTable[stgIndex] <= {stgPos, stgSpeed, stgTime[15:0], stgTime[31:16],
                              regWdata[15:0], regWdata[22:16]};
  end

  wire [31:0] axisInfo0 = {13'h0000, originFixed[0], axisErr[0], engBusy[0],
                           errCode[0], 1'b0, stepWord[0]};
  wire [31:0] axisInfo1 = {13'h0000, originFixed[1], axisErr[1], engBusy[1],
                           errCode[1], 1'b0, stepWord[1]};
  wire [31:0] readValue =
    (regAddr == `PS_REG_STATUS)      ? {27'h0000000, status} :
    (regAddr == `PS_REG_MASK)        ? {27'h0000000, mask} :
    (regAddr == `PS_REG_CONTROL)     ? {27'h0000000, stopReq, 2'h0, advancedMode} :
    (regAddr == `PS_REG_AXIS_X)      ? axisInfo0 :
    (regAddr == `PS_REG_AXIS_Y)      ? axisInfo1 :
    (regAddr == `PS_REG_POS_X)       ? position[0] :
    (regAddr == `PS_REG_POS_Y)       ? position[1] :
    (regAddr == `PS_REG_MCODE)       ? {mCodeOut[1], mCodeOut[0]} :
    (regAddr == `PS_REG_STEP_INDEX)  ? {25'h0000000, stgIndex} :
    (regAddr == `PS_REG_STEP_POS)    ? stgPos :
    (regAddr == `PS_REG_STEP_SPEED)  ? stgSpeed :
    (regAddr == `PS_REG_STEP_TIME)   ? stgTime :
    (regAddr == `PS_REG_SPEED_LIMIT) ? speedLimit : 32'h00000000;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      regRdata <= 32'h00000000;
    else
      regRdata <= regRead ? readValue : 32'h00000000;
  end

  assign axisXErrorFlag  = axisErr[0];
  assign axisYErrorFlag  = axisErr[1];
  assign axisXFinishFlag = finishFlag[0];
  assign axisYFinishFlag = finishFlag[1];
  assign axisXBusyFlag   = engBusy[0] | chainPending[0];
  assign axisYBusyFlag   = engBusy[1] | chainPending[1];
endmodule

/* include/positioning_start_defines.svh */
/*
  Offsets, field positions, reset values and timing counts of the
  two-axis positioning start front end. Assumes a 10 MHz ref_clk.
*/
`ifndef POSITIONING_START_DEFINES_SVH
`define POSITIONING_START_DEFINES_SVH

// timing
`define PS_CLK_HZ          32'h00989680
`define PS_CLK_PERIOD_NS   32'h00000064
`define PS_DWELL_UNIT_US   32'h000003E8
`define PS_MS_CYCLES       (`PS_DWELL_UNIT_US * 1000 / `PS_CLK_PERIOD_NS)

// register offsets
`define PS_REG_STATUS      8'h00
`define PS_REG_MASK        8'h04
`define PS_REG_CONTROL     8'h08
`define PS_REG_AXIS_X      8'h0C
`define PS_REG_AXIS_Y      8'h10
`define PS_REG_POS_X       8'h14
`define PS_REG_POS_Y       8'h18
`define PS_REG_MCODE       8'h1C
`define PS_REG_STEP_INDEX  8'h20
`define PS_REG_STEP_POS    8'h24
`define PS_REG_STEP_SPEED  8'h28
`define PS_REG_STEP_TIME   8'h2C
`define PS_REG_STEP_CTRL   8'h30
`define PS_REG_SPEED_LIMIT 8'h34

// reset values
`define PS_MASK_RESET      5'h00
`define PS_SPEED_LIMIT_RST 32'h000186A0

// control word fields
`define PS_CW_METHOD_BIT   0
`define PS_CW_COORD_BIT    4
`define PS_CW_ACCEL_LSB    5
`define PS_CW_ACCEL_MSB    6
`define PS_CW_PATTERN_LSB  10
`define PS_CW_PATTERN_MSB  11
`define PS_CW_REPEAT_BIT   12

// status bits
`define PS_ST_INSTR_ERR    0
`define PS_ST_ERR_X        1
`define PS_ST_FIN_X        3

// step range and error codes
`define PS_STEP_MAX_STD    7'h1E
`define PS_STEP_MAX_ADV    7'h50
`define PS_STEP_DEPTH      81
`define PS_ERR_NO_ORIGIN   8'hE0
`define PS_ERR_STEP_RANGE  8'hE1

`endif

/* include/positioning_start_pkg.sv */
/*
  Types shared by the positioning start front end and its axis engine.
  Assumes the defines header for field positions.
*/
package positioning_start_pkg;

  typedef logic [6:0] step_t;

  typedef enum logic [1:0] {PAT_END, PAT_CONTINUED, PAT_INCESSANT} op_pattern_e;

  typedef struct packed {
    logic [15:0]        slot;
    logic [15:0]        axis;
    logic signed [31:0] targetPos;
    logic [31:0]        targetSpeed;
    logic [15:0]        dwellMs;
    logic [15:0]        mCode;
    logic [15:0]        controlWord;
  } direct_cmd_s;

  typedef struct packed {
    logic [15:0] slot;
    logic [15:0] axis;
    logic [15:0] step;
  } indirect_cmd_s;

  typedef struct packed {
    logic signed [31:0] pos;
    logic [31:0]        speed;
    logic [15:0]        dwellMs;
    logic [15:0]        mCode;
    logic [15:0]        ctrl;
    step_t              repeatStep;
  } step_entry_s;

  typedef struct packed {
    logic signed [31:0] targetPos;
    logic [31:0]        targetSpeed;
    logic [15:0]        dwellMs;
    logic [15:0]        mCode;
    logic               speedMode;
    logic               incremental;
    logic [1:0]         accelSel;
    op_pattern_e        pattern;
    logic               repeatMethod;
    step_t              repeatStep;
  } job_s;

endpackage

/* hw/axis_motion_engine.sv */
/*
  One axis: runs a latched job to its goal or until stopReq at the job speed capped by speedLimit, waits the
  dwell unless the step is incessant, then pulses done. Assumes msTick is one cycle per millisecond.
*/
`timescale 1ns/1ps
`include "positioning_start_defines.svh"
module axis_motion_engine
  import positioning_start_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               sys_rst,
  input  wire logic               start,
  input  wire job_s               job,
  input  wire logic               stopReq,
  input  wire logic               msTick,
  input  wire logic [31:0]        speedLimit,
  output logic                    busy,
  output logic                    done,
  output logic signed [31:0]      position,
  output logic [15:0]             mCode,
  output logic                    pulseOut,
  output logic                    dirOut,
  output logic [1:0]              accelSel
);
  typedef enum logic [1:0] {IDLE, RUN, DWELL} eng_state_e;

  eng_state_e         state;
  job_s               jobQ;
  logic signed [31:0] goal;
  logic [31:0]        acc;
  logic [15:0]        dwellCnt;

  wire [31:0]        speedEff  = (jobQ.targetSpeed > speedLimit) ? speedLimit : jobQ.targetSpeed;
  wire [32:0]        accSum    = {1'b0, acc} + {1'b0, speedEff};
  wire               stepDue   = accSum >= {1'b0, `PS_CLK_HZ};
  wire               atGoal    = !jobQ.speedMode && (position == goal);
  wire               moveUp    = jobQ.speedMode ? !jobQ.targetPos[31] : (goal > position);
  wire signed [31:0] startGoal = job.incremental ? position + job.targetPos : job.targetPos;
  // incessant steps hand over without the dwell pause
  wire               dwellOver = (jobQ.pattern == PAT_INCESSANT) || (dwellCnt == jobQ.dwellMs);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state    <= IDLE;
      jobQ     <= '0;
      goal     <= 32'sh00000000;
      acc      <= 32'h00000000;
      dwellCnt <= 16'h0000;
      busy     <= 1'b0;
      done     <= 1'b0;
      position <= 32'sh00000000;
      mCode    <= 16'h0000;
      pulseOut <= 1'b0;
      dirOut   <= 1'b0;
      accelSel <= 2'h0;
    end
    else
    begin
      done     <= 1'b0;
      pulseOut <= 1'b0;
      unique case (state)
        IDLE:
          if (start)
          begin
            jobQ     <= job;
            goal     <= startGoal;
            acc      <= 32'h00000000;
            busy     <= 1'b1;
            accelSel <= job.accelSel;
            state    <= RUN;
          end
        RUN:
          if (atGoal || stopReq)
          begin
            dwellCnt <= 16'h0000;
            state    <= DWELL;
          end
          else
          begin
            acc <= stepDue ? 32'(accSum - {1'b0, `PS_CLK_HZ}) : accSum[31:0];
            if (stepDue)
            begin
              pulseOut <= 1'b1;
              dirOut   <= moveUp;
              position <= moveUp ? position + 32'sh00000001 : position - 32'sh00000001;
            end
          end
        DWELL:
          if (dwellOver)
          begin
            done  <= 1'b1;
            busy  <= 1'b0;
            state <= IDLE;
            if (jobQ.mCode != 16'h0000)
              mCode <= jobQ.mCode;
          end
          else if (msTick)
            dwellCnt <= dwellCnt + 16'h0001;
      endcase
    end
  end
endmodule

/* verif/positioning_start_commands_checker.sv */
/* port assertions for the start front end
   assumes ref_clk domain, sync sys_rst */
`timescale 1ns/1ps
module positioning_start_commands_checker
  import positioning_start_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        scanPulse,
  input wire logic        directStartCmd,
  input wire direct_cmd_s directOperands,
  input wire logic        indirectStartCmd,
  input wire logic [1:0]  originFixed,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  input wire logic        instructionErrorFlag,
  input wire logic        axisXErrorFlag,
  input wire logic        axisYErrorFlag,
  input wire logic        axisXFinishFlag,
  input wire logic        axisXBusyFlag
);
  logic prevDir;
  wire  dEdge = scanPulse && directStartCmd && !prevDir;
  wire  badAx = directOperands.axis > 16'h0001;
  wire  onX   = directOperands.axis == 16'h0000;
  wire  freeX = !axisXBusyFlag && !axisXErrorFlag;
  always_ff @(posedge ref_clk)
    if (sys_rst || scanPulse)
      prevDir <= directStartCmd && !sys_rst;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_bad_axis; dEdge && badAx |=> instructionErrorFlag; endproperty
  a_bad_axis: assert property (p_bad_axis)
    else $error("bad axis not flagged");
  property p_keep_err;
    dEdge && badAx |=> $stable(axisXErrorFlag) && $stable(axisYErrorFlag);
  endproperty
  a_keep_err: assert property (p_keep_err)
    else $error("axis error moved on bad axis");
  property p_start; dEdge && onX && originFixed[0] && freeX |=> axisXBusyFlag; endproperty
  a_start: assert property (p_start)
    else $error("direct start not taken");
  property p_no_origin;
    dEdge && onX && !originFixed[0] && freeX |=> (axisXErrorFlag && !axisXBusyFlag) [*3];
  endproperty
  a_no_origin: assert property (p_no_origin)
    else $error("start without origin");
  property p_err_ignore; dEdge && onX && axisXErrorFlag |=> !axisXBusyFlag; endproperty
  a_err_ignore: assert property (p_err_ignore)
    else $error("start taken in error");
  property p_busy_ignore;
    dEdge && onX && axisXBusyFlag |=> !instructionErrorFlag && $stable(axisXErrorFlag);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore)
    else $error("busy start not ignored");
  property p_fin_rise; $rose(axisXFinishFlag) |-> $past(scanPulse); endproperty
  a_fin_rise: assert property (p_fin_rise)
    else $error("finish off scan");
  property p_fin_fall; axisXFinishFlag && scanPulse |=> !axisXFinishFlag; endproperty
  a_fin_fall: assert property (p_fin_fall)
    else $error("finish longer than a scan");
  // level held over scans must not restart
  property p_edge_once;
    scanPulse && directStartCmd && prevDir && !indirectStartCmd && !axisXBusyFlag
      |=> !axisXBusyFlag;
  endproperty
  a_edge_once: assert property (p_edge_once)
    else $error("level restarted axis");
  property p_rd_idle; !regRead |=> regRdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside slot");
  c_bad: cover property (dEdge && badAx);
  c_fin: cover property ($rose(axisXFinishFlag));
  c_err: cover property ($rose(axisXErrorFlag));
endmodule

/* verif/host_scan_model.sv */
/* host scan model: scan pulse and command levels
   assumes bench holds wants across scans */
`timescale 1ns/1ps
module host_scan_model
#(
  parameter int SCAN = 8
)
(
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic wantDirect,
  input  wire logic wantIndirect,
  output logic      scanPulse,
  output logic      directStartCmd,
  output logic      indirectStartCmd
);
  logic [7:0] scanCount;
  assign scanPulse = scanCount == 8'(SCAN - 1);
  // levels move only at scan ends, like a real program
  always_ff @(posedge ref_clk)
  begin
    scanCount <= (sys_rst || scanPulse) ? 8'h00 : scanCount + 8'h01;
    if (sys_rst || scanPulse)
    begin
      directStartCmd   <= wantDirect && !sys_rst;
      indirectStartCmd <= wantIndirect && !sys_rst;
    end
  end
endmodule

/* verif/positioning_start_commands_tb.sv */
/* self-checking bench for the start front end
   assumes host_scan_model drives scans */
`timescale 1ns/1ps
module positioning_start_commands_tb
  import positioning_start_pkg::*;
;
  logic          ref_clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic          wantD = 1'b0;
  logic          wantI = 1'b0;
  logic          scanPulse, directStartCmd, indirectStartCmd, irq;
  direct_cmd_s   directOperands = '0;
  indirect_cmd_s indirectOperands = '0;
  logic [1:0]    originFixed = 2'h0;
  logic [7:0]    regAddr = 8'h00;
  logic [31:0]   regWdata = 32'h0, regRdata, d;
  logic          regWrite = 1'b0, regRead = 1'b0, instructionErrorFlag;
  logic          axisXErrorFlag, axisYErrorFlag, axisXFinishFlag, axisXBusyFlag;
  int            fails = 0, samples_checked = 0;
  always #50 ref_clk = ~ref_clk;
  host_scan_model #(.SCAN(8)) i_host_scan_model (.ref_clk, .sys_rst,
    .wantDirect(wantD), .wantIndirect(wantI), .scanPulse, .directStartCmd, .indirectStartCmd);
  positioning_start_commands #(.MS_CYCLES(4)) i_positioning_start_commands (.ref_clk,
    .sys_rst, .scanPulse, .directStartCmd, .directOperands, .indirectStartCmd,
    .indirectOperands, .originFixed, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .instructionErrorFlag, .axisXErrorFlag, .axisYErrorFlag, .axisXFinishFlag,
    .axisYFinishFlag(), .axisXBusyFlag, .axisYBusyFlag(), .axisPulse(), .axisDir(), .irq);
  task automatic check(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
    @(posedge ref_clk);
  endtask
  task automatic issue(input logic ind);
    if (ind) wantI <= 1'b1; else wantD <= 1'b1;
    repeat (2) @(posedge ref_clk iff scanPulse);
    wantD <= 1'b0;
    wantI <= 1'b0;
    repeat (2) @(posedge ref_clk iff scanPulse);
  endtask
  task automatic direct(input logic [15:0] ax, input logic [31:0] p, input logic [15:0] cw);
    directOperands <= '{16'h0000, ax, p, 32'h000186A0, 16'h0001, 16'h007B, cw};
    issue(1'b0);
  endtask
  task automatic indirect(input logic [15:0] st);
    indirectOperands <= '{16'h0000, 16'h0000, st};
    issue(1'b1);
  endtask
  task automatic idle();
    for (int n = 0; n < 3000 && axisXBusyFlag !== 1'b0; n++) @(posedge ref_clk);
    check(axisXBusyFlag, 1'b0);
  endtask
  task automatic step(input logic [31:0] idx, p);
    wr(8'h20, idx);
    wr(8'h24, p);
    wr(8'h28, 32'h000186A0);
    wr(8'h2C, 32'h0);
    wr(8'h30, 32'h00000010);
  endtask
  task automatic t_bad_axis();
    originFixed <= 2'h3;
    direct(16'h0002, 32'h5, 16'h0);
    rd(8'h00);
    check(d & 32'h7, 32'h1);
    wr(8'h04, 32'h1);
    repeat (2) @(posedge ref_clk);
    #1 check(irq, 1'b1);
    wr(8'h00, 32'h1);
    repeat (2) @(posedge ref_clk);
    #1 check(irq, 1'b0);
    rd(8'h3C);
    check(d, 32'h0);
  endtask
  task automatic t_origin();
    originFixed <= 2'h2;
    direct(16'h0000, 32'h5, 16'h0);
    rd(8'h0C);
    check(d & 32'h2FF00, 32'h2E000);
    originFixed <= 2'h3;
    direct(16'h0000, 32'h5, 16'h0);
    check(axisXBusyFlag, 1'b0);
    wr(8'h08, 32'h2);
    @(posedge ref_clk);
    check(axisXErrorFlag, 1'b0);
  endtask
  task automatic t_run();
    int hi;
    hi = 0;
    direct(16'h0000, 32'h5, 16'h0020);
    direct(16'h0000, 32'h9, 16'h0010);
    idle();
    repeat (24) @(posedge ref_clk) if (axisXFinishFlag === 1'b1) hi++;
    check(hi, 8);
    rd(8'h14);
    check(d, 32'h5);
    rd(8'h1C);
    check(d & 32'hFFFF, 32'h7B);
    direct(16'h0000, 32'h3, 16'h0010);
    idle();
    rd(8'h14);
    check(d, 32'h8);
  endtask
  task automatic t_ind();
    step(3, 7);
    step(4, 1);
    indirect(16'h0003);
    idle();
    rd(8'h14);
    check(d, 32'hF);
    indirect(16'h0000);
    idle();
    rd(8'h14);
    check(d, 32'h10);
    rd(8'h0C);
    check(d & 32'h7F, 32'h5);
    wr(8'h00, 32'h1F);
    indirect(16'h001F);
    rd(8'h00);
    check(d & 32'h3, 32'h2);
    rd(8'h0C);
    check(d & 32'h2FF00, 32'h2E100);
    direct(16'h0001, 32'h2, 16'h0);
    repeat (300) @(posedge ref_clk);
    rd(8'h18);
    check(d, 32'h2);
  endtask
  initial
  begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_bad_axis();
    t_origin();
    t_run();
    t_ind();
    tally_and_finish();
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    tally_and_finish();
  end
endmodule
bind positioning_start_commands positioning_start_commands_checker
  i_positioning_start_commands_checker (.ref_clk, .sys_rst, .scanPulse, .directStartCmd,
  .directOperands, .indirectStartCmd, .originFixed, .regRead, .regRdata,
  .instructionErrorFlag, .axisXErrorFlag, .axisYErrorFlag, .axisXFinishFlag, .axisXBusyFlag);
